// >>> dv/sltc_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module sltc_rx_model (
  input wire logic clk_i,
  input wire logic want_pin_i,
  input wire logic want_ts_i,
  output logic sync_pin_n_o = 1'b1,
  output logic ts_n_o = 1'b1
);
  // Requests are active low and move only just after an edge
  always @(posedge clk_i) begin
    sync_pin_n_o <= ~want_pin_i;
    ts_n_o <= ~want_ts_i;
  end
endmodule
`default_nettype wire

// >>> dv/sltc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sltc_top_tb;
  import sltc_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, sync_pin_n, ts_n, scramble, sync_req, link_rst_n, ts_en, err;
  logic want_pin = 1'b0, want_ts = 1'b0, enc = 1'b0, ila = 1'b0, clk_en = 1'b1;
  logic [3:0] lanes = 4'h2;
  logic [8:0] sample = 9'h000, sample_q;
  logic [7:0] lane_act, mode;
  logic [127:0] lane_data;
  int errors = 0, num_checks = 0;
  always #5 clk = ~clk;
  sltc_rx_model i_rx (.clk_i(clk), .want_pin_i(want_pin), .want_ts_i(want_ts),
    .sync_pin_n_o(sync_pin_n), .ts_n_o(ts_n));
  sltc_top #(.LANES(8)) i_dut (.clk_i(clk), .reset_n_i(reset_n), .clk_en_i(clk_en),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .dedicated_sync_pin_i(sync_pin_n), .timestamp_diff_input_i(ts_n),
    .enc_64b66b_i(enc), .active_lanes_i(lanes), .ila_mf2_i(ila), .sample_i(sample),
    .lane_active_o(lane_act), .lane_data_o(lane_data), .sample_o(sample_q),
    .scramble_o(scramble), .sync_request_o(sync_req), .link_reset_n_o(link_rst_n),
    .timestamp_receiver_enable_o(ts_en), .link_mode_select_o(mode));
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Printed offsets are word indices, byte address is four times that
  function automatic logic [11:0] ba(input logic [11:0] idx);
    ba = {idx[9:0], 2'b00};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Fields move only with the link held off
  task automatic cfg(input logic [7:0] ctrl, input logic [7:0] test);
    apb(1'b1, ba(SLTC_OFF_ENABLE), 32'h2);
    apb(1'b1, ba(SLTC_OFF_CTRL), {24'h0, ctrl});
    apb(1'b1, ba(SLTC_OFF_TEST), {24'h0, test});
    apb(1'b1, ba(SLTC_OFF_ENABLE), 32'h3);
    wait_cyc(6);
  endtask
  ////////////////////////////////////////////////////////////////
  logic [7:0] rtab [4] = '{8'h03, 8'h00, 8'h00, 8'h00};
  logic [4:0] stab [5] = '{5'h01, 5'h0D, 5'h05, 5'h12, 5'h1B};
  initial begin
    wait_cyc(10);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ba(SLTC_OFF_CTRL + 12'(i)), 32'h0);
      chk("reset value", rd, {24'h0, rtab[i]});
    end
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    $display("test registers done");
    apb(1'b1, ba(SLTC_OFF_ENABLE), 32'h0);
    wait_cyc(3);
    chk("link held", {31'h0, link_rst_n}, 32'h0);
    chk("mode gated", {24'h0, mode}, 32'h0);
    $display("test disable done");
    cfg(8'h03, 8'h00);
    sample <= 9'h1F3;
    wait_cyc(3);
    chk("twos complement", {23'h0, sample_q}, 32'h1F3);
    cfg(8'h01, 8'h00);
    chk("offset binary", {23'h0, sample_q}, 32'h0F3);
    chk("lanes low", {24'h0, lane_act}, 32'h03);
    lanes <= 4'h4;
    cfg(8'h11, 8'h00);
    chk("lanes upper", {24'h0, lane_act}, 32'hF0);
    lanes <= 4'h2;
    $display("test format lanes done");
    for (int i = 0; i < 4; i++) begin
      enc <= i[1];
      cfg({7'h0, i[0]}, 8'h00);
      chk("scramble", {31'h0, scramble}, {31'h0, i[1] | i[0]});
    end
    enc <= 1'b0;
    $display("test scrambler done");
    for (int s = 0; s < 3; s++) begin
      cfg({4'h0, 2'(s), 2'h3}, 8'h00);
      for (int p = 0; p < 4; p++) begin
        want_pin <= p[0];
        want_ts <= p[1];
        wait_cyc(6);
        chk("sync source", {31'h0, sync_req},
          {31'h0, (s == 0) ? p[0] : (s == 1) ? p[1] : 1'b0});
        chk("ts receiver", {31'h0, ts_en}, 32'h1);
      end
    end
    apb(1'b1, ba(SLTC_OFF_SYNC), 32'h0);
    wait_cyc(6);
    chk("software sync", {31'h0, sync_req}, 32'h1);
    apb(1'b1, ba(SLTC_OFF_SYNC), 32'h1);
    want_pin <= 1'b0;
    want_ts <= 1'b0;
    $display("test sync done");
    apb(1'b1, ba(SLTC_OFF_ENABLE), 32'h2);
    apb(1'b1, ba(SLTC_OFF_DID), 32'h5A);
    apb(1'b1, ba(SLTC_OFF_MODE), 32'h15);
    apb(1'b0, ba(SLTC_OFF_DID), 32'h0);
    chk("device id", rd, 32'h5A);
    cfg(8'h03, 8'h00);
    ila <= 1'b1;
    wait_cyc(3);
    chk("id in alignment", {24'h0, lane_data[7:0]}, 32'h5A);
    chk("mode copy", {24'h0, mode}, 32'h15);
    ila <= 1'b0;
    $display("test device id done");
    for (int c = 1; c < 18; c++) begin
      cfg(8'h03, 8'(c));
      apb(1'b0, ba(SLTC_OFF_TEST), 32'h0);
      chk("test code", rd, 32'(c));
      if (c == 10 || c == 11 || c == 15) begin
        chk("fixed lane0", {16'h0, lane_data[15:0]},
          (c == 10) ? 32'h0 : (c == 11) ? 32'hFFFF : {16'h0, SLTC_CLK_PAT});
        chk("fixed lane1", {16'h0, lane_data[31:16]},
          (c == 10) ? 32'h0 : (c == 11) ? 32'hFFFF : {16'h0, SLTC_CLK_PAT});
      end
    end
    $display("test patterns done");
    for (int i = 0; i < 5; i++) begin
      cfg(8'h03, {3'h0, stab[i]});
      sample <= 9'h000;
      wait_cyc(3);
      rd = {16'h0, lane_data[15:0]};
      sample <= 9'h0FF;
      wait_cyc(3);
      num_checks++;
      // Only the transport pattern holds still; PRBS and normal payload move
      if ((rd === {16'h0, lane_data[15:0]}) == (i != 2)) begin
        errors++;
        $display("ERROR payload tracking expected %h seen %h", i, rd);
      end
      if (i >= 3) begin
        chk("reserved payload", {16'h0, lane_data[15:0]}, 32'h0FF);
      end
    end
    $display("test normal reserved done");
    cfg(8'h03, 8'h04);
    clk_en <= 1'b0;
    wait_cyc(2);
    rd = {16'h0, lane_data[15:0]};
    wait_cyc(3);
    chk("enable freeze", {16'h0, lane_data[15:0]}, rd);
    clk_en <= 1'b1;
    wait_cyc(3);
    num_checks++;
    if ({16'h0, lane_data[15:0]} === rd) begin
      errors++;
      $display("ERROR ramp resume expected change seen %h", rd);
    end
    $display("test clock enable done");
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire

// >>> include/sltc_pkg.sv
package sltc_pkg;
  localparam logic [11:0] SLTC_OFF_ENABLE = 12'h200;
  localparam logic [11:0] SLTC_OFF_MODE = 12'h201;
  localparam logic [11:0] SLTC_OFF_SYNC = 12'h203;
  localparam logic [11:0] SLTC_OFF_CTRL = 12'h204;
  localparam logic [11:0] SLTC_OFF_TEST = 12'h205;
  localparam logic [11:0] SLTC_OFF_DID = 12'h206;
  localparam logic [11:0] SLTC_OFF_LINK_FRAME_CHARACTER = 12'h207;
  localparam logic [7:0] SLTC_RST_ENABLE = 8'h01;
  localparam logic [7:0] SLTC_RST_MODE = 8'h00;
  localparam logic [7:0] SLTC_RST_SYNC = 8'h01;
  localparam logic [7:0] SLTC_RST_CTRL = 8'h03;
  localparam logic [7:0] SLTC_RST_TEST = 8'h00;
  localparam logic [7:0] SLTC_RST_DID = 8'h00;
  localparam logic [7:0] SLTC_RST_LINK_FRAME_CHARACTER = 8'h00;
  localparam int SLTC_BIT_SCR = 0;
  localparam int SLTC_BIT_FMT = 1;
  localparam int SLTC_BIT_SYNC_LO = 2;
  localparam int SLTC_BIT_UPPER = 4;
  localparam logic [1:0] SLTC_SYNC_PIN = 2'h0;
  localparam logic [1:0] SLTC_SYNC_TIMESTAMP_DIFF_INPUT = 2'h1;
  localparam logic [1:0] SLTC_SYNC_SW = 2'h2;
  localparam logic [3:0] SLTC_UPPER_BASE = 4'h4;
  localparam logic [15:0] SLTC_CLK_PAT = 16'h00FF;
  localparam logic [7:0] SLTC_D21_5 = 8'hB5;
  localparam logic [7:0] SLTC_K28_5 = 8'hBC;
  localparam logic [7:0] SLTC_K28_7 = 8'hFC;
  localparam logic [7:0] SLTC_RPAT = 8'hBE;
  localparam logic [7:0] SLTC_TPAT = 8'hA5;

  typedef enum logic [16:0] {
    TP_NORMAL = 17'h00001, TP_PRBS7 = 17'h00002, TP_PRBS15 = 17'h00004,
    TP_PRBS23 = 17'h00008, TP_RAMP = 17'h00010, TP_TRANSPORT = 17'h00020,
    TP_D215 = 17'h00040, TP_K285 = 17'h00080, TP_ILA = 17'h00100,
    TP_RPAT = 17'h00200, TP_LOW = 17'h00400, TP_HIGH = 17'h00800,
    TP_PRBS9 = 17'h01000, TP_PRBS31 = 17'h02000, TP_CLOCK = 17'h04000,
    TP_K287 = 17'h08000, TP_SPARE = 17'h10000
  } sltc_tp_e;

  typedef struct packed {
    logic upper_lane_placement;
    logic [1:0] sync_source;
    logic sample_number_format;
    logic scrambler_on;
  } sltc_ctrl_s;

  function automatic sltc_tp_e sltc_decode(input logic [4:0] code);
    case (code)
      5'h01: sltc_decode = TP_PRBS7;
      5'h02: sltc_decode = TP_PRBS15;
      5'h03: sltc_decode = TP_PRBS23;
      5'h04: sltc_decode = TP_RAMP;
      5'h05: sltc_decode = TP_TRANSPORT;
      5'h06: sltc_decode = TP_D215;
      5'h07: sltc_decode = TP_K285;
      5'h08: sltc_decode = TP_ILA;
      5'h09: sltc_decode = TP_RPAT;
      5'h0A: sltc_decode = TP_LOW;
      5'h0B: sltc_decode = TP_HIGH;
      5'h0D: sltc_decode = TP_PRBS9;
      5'h0E: sltc_decode = TP_PRBS31;
      5'h0F: sltc_decode = TP_CLOCK;
      5'h10: sltc_decode = TP_K287;
      default: sltc_decode = TP_NORMAL;
    endcase
  endfunction
endpackage

// >>> rtl/sltc_top.sv
`timescale 1ns/1ps
`default_nettype none
module sltc_top
  import sltc_pkg::*;
#(
  parameter int LANES = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic dedicated_sync_pin_i,
  input wire logic timestamp_diff_input_i,
  input wire logic enc_64b66b_i,
  input wire logic [3:0] active_lanes_i,
  input wire logic ila_mf2_i,
  input wire logic [8:0] sample_i,
  output logic [LANES-1:0] lane_active_o,
  output logic [LANES*16-1:0] lane_data_o,
  output logic [8:0] sample_o,
  output logic scramble_o,
  output logic sync_request_o,
  output logic link_reset_n_o,
  output logic timestamp_receiver_enable_o,
  output logic [7:0] link_mode_select_o
);

  logic [7:0] enable_q;
  logic [7:0] mode_q;
  logic [7:0] sync_q;
  sltc_ctrl_s ctrl_q;
  logic [4:0] test_q;
  logic [7:0] did_q;
  logic [7:0] link_frame_character_q;
  logic link_enable;
  logic acc;
  logic wr;
  logic mapped;
  logic [31:0] rd_d;
  sltc_tp_e tp;

  assign link_enable = enable_q[0];
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i & clk_en_i;
  assign tp = sltc_decode(test_q);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[9:0]);
  endfunction

  // Word index is the printed offset; byte address is four times it
  always_comb begin
    rd_d = 32'h0000_0000;
    mapped = 1'b1;
    if (hit(paddr_i, SLTC_OFF_ENABLE)) begin
      rd_d[7:0] = enable_q;
    end else if (hit(paddr_i, SLTC_OFF_MODE)) begin
      rd_d[7:0] = mode_q;
    end else if (hit(paddr_i, SLTC_OFF_SYNC)) begin
      rd_d[7:0] = sync_q;
    end else if (hit(paddr_i, SLTC_OFF_CTRL)) begin
      rd_d[7:0] = {3'h0, ctrl_q};
    end else if (hit(paddr_i, SLTC_OFF_TEST)) begin
      rd_d[7:0] = {3'h0, test_q};
    end else if (hit(paddr_i, SLTC_OFF_DID)) begin
      rd_d[7:0] = did_q;
    end else if (hit(paddr_i, SLTC_OFF_LINK_FRAME_CHARACTER)) begin
      rd_d[7:0] = link_frame_character_q;
    end else begin
      mapped = 1'b0;
    end
  end

  // Zero-wait slave: pready only in the access cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
      prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? rd_d : 32'h0000_0000;
    end
  end

  // Writes land on the access edge, once pready is already high
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      enable_q <= SLTC_RST_ENABLE;
      mode_q <= SLTC_RST_MODE;
      sync_q <= SLTC_RST_SYNC;
      ctrl_q <= sltc_ctrl_s'(SLTC_RST_CTRL[4:0]);
      test_q <= SLTC_RST_TEST[4:0];
      did_q <= SLTC_RST_DID;
      link_frame_character_q <= SLTC_RST_LINK_FRAME_CHARACTER;
    end else if (wr && pready_o) begin
      if (hit(paddr_i, SLTC_OFF_ENABLE)) enable_q <= pwdata_i[7:0];
      if (hit(paddr_i, SLTC_OFF_MODE)) mode_q <= pwdata_i[7:0];
      if (hit(paddr_i, SLTC_OFF_SYNC)) sync_q <= pwdata_i[7:0];
      if (hit(paddr_i, SLTC_OFF_CTRL)) ctrl_q <= sltc_ctrl_s'(pwdata_i[4:0]);
      if (hit(paddr_i, SLTC_OFF_TEST)) test_q <= pwdata_i[4:0];
      if (hit(paddr_i, SLTC_OFF_DID)) did_q <= pwdata_i[7:0];
      if (hit(paddr_i, SLTC_OFF_LINK_FRAME_CHARACTER)) link_frame_character_q <= pwdata_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync request selection

  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pin_s1_q <= 2'h3;
      pin_s2_q <= 2'h3;
    end else if (clk_en_i) begin
      pin_s1_q <= {timestamp_diff_input_i, dedicated_sync_pin_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Active-low requests; the software bit always contributes
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync_request_o <= 1'b0;
      timestamp_receiver_enable_o <= 1'b0;
    end else if (clk_en_i) begin
      case (ctrl_q.sync_source)
        SLTC_SYNC_PIN: sync_request_o <= ~sync_q[0] | ~pin_s2_q[0];
        SLTC_SYNC_TIMESTAMP_DIFF_INPUT: sync_request_o <= ~sync_q[0] | ~pin_s2_q[1];
        default: sync_request_o <= ~sync_q[0];
      endcase
      timestamp_receiver_enable_o <= enable_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern generators, held in reset while the link is off

  logic [30:0] prbs_q;
  logic [15:0] ramp_q;
  logic [15:0] pat_d;

  function automatic logic [15:0] prbs_step(input logic [30:0] s, input sltc_tp_e t);
    logic [30:0] r;
    logic fb;
    r = s;
    for (int i = 0; i < 16; i++) begin
      case (t)
        TP_PRBS7: fb = r[6] ^ r[5];
        TP_PRBS9: fb = r[8] ^ r[4];
        TP_PRBS15: fb = r[14] ^ r[13];
        TP_PRBS23: fb = r[22] ^ r[17];
        default: fb = r[30] ^ r[27];
      endcase
      r = {r[29:0], fb};
    end
    prbs_step = r[15:0];
  endfunction

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !link_enable) begin
      prbs_q <= 31'h7FFF_FFFF;
      ramp_q <= 16'h0000;
    end else if (clk_en_i) begin
      prbs_q <= {prbs_q[14:0], prbs_step(prbs_q, tp)};
      ramp_q <= ramp_q + 16'h0101;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane payload

  logic [8:0] samp_fmt;
  assign samp_fmt = ctrl_q.sample_number_format ? sample_i : {~sample_i[8], sample_i[7:0]};

  always_comb begin
    case (tp)
      TP_PRBS7, TP_PRBS9, TP_PRBS15, TP_PRBS23, TP_PRBS31: pat_d = prbs_q[15:0];
      TP_RAMP: pat_d = ramp_q;
      TP_TRANSPORT: pat_d = {SLTC_TPAT, link_frame_character_q};
      TP_D215: pat_d = {SLTC_D21_5, SLTC_D21_5};
      TP_K285: pat_d = {SLTC_K28_5, SLTC_K28_5};
      TP_K287: pat_d = {SLTC_K28_7, SLTC_K28_7};
      TP_ILA: pat_d = ila_mf2_i ? {did_q, SLTC_K28_5} : {SLTC_K28_5, SLTC_K28_5};
      TP_RPAT: pat_d = {SLTC_RPAT, ~SLTC_RPAT};
      TP_LOW: pat_d = 16'h0000;
      TP_HIGH: pat_d = 16'hFFFF;
      TP_CLOCK: pat_d = SLTC_CLK_PAT;
      TP_NORMAL: pat_d = ila_mf2_i ? {8'h00, did_q} : {7'h00, samp_fmt};
      default: pat_d = {7'h00, samp_fmt};
    endcase
  end

  logic [LANES-1:0] act_d;
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      if (ctrl_q.upper_lane_placement) begin
        act_d[l] = (l >= 4) && (l < 4 + int'(active_lanes_i));
      end else begin
        act_d[l] = l < int'(active_lanes_i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !link_enable) begin
      lane_active_o <= '0;
      lane_data_o <= '0;
      sample_o <= 9'h000;
      scramble_o <= 1'b0;
      link_reset_n_o <= 1'b0;
      link_mode_select_o <= 8'h00;
    end else if (clk_en_i) begin
      lane_active_o <= act_d;
      for (int l = 0; l < LANES; l++) begin
        lane_data_o[l*16 +: 16] <= act_d[l] ? pat_d : 16'h0000;
      end
      sample_o <= samp_fmt;
      scramble_o <= enc_64b66b_i | ctrl_q.scrambler_on;
      link_reset_n_o <= 1'b1;
      link_mode_select_o <= mode_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_link_off_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !$past(link_enable) |-> (lane_active_o == '0) && !link_reset_n_o)
    else $error("link output active while link disabled");
  a_scr_64b: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    link_enable && clk_en_i && enc_64b66b_i |=> scramble_o)
    else $error("64b66b link not scrambled");
  a_scr_8b: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    link_enable && clk_en_i && !enc_64b66b_i |=> scramble_o == $past(ctrl_q.scrambler_on))
    else $error("8b10b scrambler not following bit");
  a_sw_sync: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && !sync_q[0] |=> sync_request_o)
    else $error("software sync not requested");
  a_sync_sw_only: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && ctrl_q.sync_source == SLTC_SYNC_SW && sync_q[0] |=> !sync_request_o)
    else $error("pin leaks into software-only sync");
  a_lane_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    link_enable && clk_en_i && test_q == 5'h0A |=> lane_data_o == '0)
    else $error("outputs not held low");
  a_upper_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    link_enable && clk_en_i && ctrl_q.upper_lane_placement |=> lane_active_o[3:0] == 4'h0)
    else $error("lower lanes used in upper placement");
  a_lower_map: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    link_enable && clk_en_i && !ctrl_q.upper_lane_placement && active_lanes_i != 4'h0
    |=> lane_active_o[0])
    else $error("lane 0 idle in normal placement");
  a_reserved_norm: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    link_enable && clk_en_i && test_q == 5'h0C && !ila_mf2_i && active_lanes_i != 4'h0
    && !ctrl_q.upper_lane_placement |=> lane_data_o[15:0] == {7'h00, $past(samp_fmt)})
    else $error("reserved code not normal");

endmodule
`default_nettype wire
